// file: design/link_host_control_pkg.sv
package link_host_control_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] HOST_CTRL_SET_OFS   = 12'h050;
    localparam logic [11:0] HOST_CTRL_CLR_OFS   = 12'h054;
    localparam logic [11:0] SELF_ID_BASE_OFS    = 12'h064;

    // Offset ranges whose registers sit in the PHY-clock domain.
    localparam logic [11:0] PHY_DOM_A_LO        = 12'h0DC;
    localparam logic [11:0] PHY_DOM_A_HI        = 12'h0F0;
    localparam logic [11:0] PHY_DOM_B_LO        = 12'h100;
    localparam logic [11:0] PHY_DOM_B_HI        = 12'h11C;

    // ------------------------------------------------------------
    // Host control field positions
    // ------------------------------------------------------------
    localparam int          CFG_PERMIT_BIT      = 23;
    localparam int          ENHANCE_BIT         = 22;
    localparam int          POWER_BIT           = 19;
    localparam int          POSTED_BIT          = 18;
    localparam int          LINK_ACTIVE_BIT     = 17;
    localparam int          SOFT_RESET_BIT      = 16;

    // ------------------------------------------------------------
    // Self-ID base pointer layout
    // ------------------------------------------------------------
    localparam int          SID_LSB             = 11;
    localparam int          SID_W               = 21;

    // ------------------------------------------------------------
    // Values after reset, and the all-ones read value for suppressed aborts
    // ------------------------------------------------------------
    localparam logic        CFG_PERMIT_RESET    = 1'b1;
    localparam logic        CTRL_BIT_RESET      = 1'b0;
    localparam logic [20:0] SID_RESET           = 21'h00000;
    localparam logic [31:0] ALL_ONES            = 32'hFFFFFFFF;

    // ------------------------------------------------------------
    // Counts of cycles
    // ------------------------------------------------------------
    localparam int          SOFT_RESET_CYCLES   = 16;

endpackage

// file: design/soft_reset_sequencer.sv
`timescale 1ns/100ps

// Holds a busy level for a fixed number of cycles after a start pulse.
module soft_reset_sequencer #(
    parameter int CYCLES = link_host_control_pkg::SOFT_RESET_CYCLES
) (
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic start,
    output logic      busy
);

    localparam int CW = $clog2(CYCLES + 1);

    typedef struct packed {
        logic          busy;
        logic [CW-1:0] count;
    } seq_state_t;

    seq_state_t state;
    seq_state_t next_state;

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------

    // A start while idle loads the counter; busy drops when it runs out.
    always_comb begin
        next_state = state;
        if (!state.busy && start) begin
            next_state.busy  = 1'b1;
            next_state.count = CW'(CYCLES - 1);
        end else if (state.busy) begin
            if (state.count == '0) begin
                next_state.busy = 1'b0;
            end else begin
                next_state.count = state.count - 1'b1;
            end
        end
    end

    // Registers the state copy.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign busy = state.busy;

endmodule

// file: design/link_host_control_selfid_ptr.sv
`timescale 1ns/100ps

module link_host_control_selfid_ptr #(
    parameter int SOFT_RESET_LEN = link_host_control_pkg::SOFT_RESET_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        reg_req,
    input  wire logic        reg_write,
    input  wire logic [11:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    output logic             reg_ack,
    output logic             reg_abort,
    input  wire logic        phy_clock_running,
    input  wire logic        abort_suppress,
    input  wire logic        eeprom_load,
    input  wire logic        eeprom_phy_config_permit,
    output logic             phy_comm_enable,
    output logic             link_traffic_enable,
    output logic             posted_write_allow_out,
    output logic             phy_enhancements_on,
    output logic             link_state_reset,
    output logic      [31:0] self_id_base_addr
);

    // Width of the busy-length counter that the software reset length check reads.
    localparam int BW = $clog2(SOFT_RESET_LEN + 1) + 1;

    typedef struct packed {
        logic          phy_config_permit;
        logic          phy_enhancement_enable;
        logic          link_power_status;
        logic          posted_write_allow;
        logic          link_active_switch;
        logic [20:0]   self_id_base;
        logic [31:0]   rdata;
        logic          ack;
        logic          abort;
        logic          traffic;
        logic [BW-1:0] busy_len;
    } bank_state_t;

    bank_state_t state;
    bank_state_t next_state;
    logic        reset_busy;
    logic        reset_start;
    logic        hit_set;
    logic        hit_clr;
    logic        hit_sid;
    logic        phy_domain;
    logic [31:0] ctrl_view;

    // ------------------------------------------------------------
    // Software reset sequencer
    // ------------------------------------------------------------

    // Runs the software reset for a fixed number of cycles.
    soft_reset_sequencer #(
        .CYCLES (SOFT_RESET_LEN)
    ) u_soft_reset (
        .ref_clk (ref_clk),
        .reset   (reset),
        .start   (reset_start),
        .busy    (reset_busy)
    );

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------

    // Decodes the mapped registers and the PHY-clock domain ranges.
    assign hit_set    = (reg_addr == link_host_control_pkg::HOST_CTRL_SET_OFS);
    assign hit_clr    = (reg_addr == link_host_control_pkg::HOST_CTRL_CLR_OFS);
    assign hit_sid    = (reg_addr == link_host_control_pkg::SELF_ID_BASE_OFS);
    assign phy_domain = ((reg_addr >= link_host_control_pkg::PHY_DOM_A_LO) &&
                         (reg_addr <= link_host_control_pkg::PHY_DOM_A_HI)) ||
                        ((reg_addr >= link_host_control_pkg::PHY_DOM_B_LO) &&
                         (reg_addr <= link_host_control_pkg::PHY_DOM_B_HI));

    // A write of 1 to the self-clearing reset bit at the set address starts a reset.
    assign reset_start = reg_req && reg_write && hit_set && !phy_domain &&
                         reg_wdata[link_host_control_pkg::SOFT_RESET_BIT];

    // ------------------------------------------------------------
    // Read view of host control
    // ------------------------------------------------------------

    // Assembles the read value; unused and reserved positions read zero.
    always_comb begin
        ctrl_view = 32'h00000000;
        ctrl_view[link_host_control_pkg::CFG_PERMIT_BIT]  = state.phy_config_permit;
        ctrl_view[link_host_control_pkg::ENHANCE_BIT]     = state.phy_enhancement_enable;
        ctrl_view[link_host_control_pkg::POWER_BIT]       = state.link_power_status;
        ctrl_view[link_host_control_pkg::POSTED_BIT]      = state.posted_write_allow;
        ctrl_view[link_host_control_pkg::LINK_ACTIVE_BIT] = state.link_active_switch;
        ctrl_view[link_host_control_pkg::SOFT_RESET_BIT]  = reset_busy;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------

    // Computes register updates, the access answer and the traffic gate.
    always_comb begin
        next_state       = state;
        next_state.ack   = 1'b0;
        next_state.abort = 1'b0;
        if (eeprom_load) begin
            next_state.phy_config_permit = eeprom_phy_config_permit;
        end
        if (reg_req) begin
            if (phy_domain && !phy_clock_running) begin
                // The PHY clock is stopped, so this access cannot complete normally.
                if (abort_suppress) begin
                    next_state.ack   = 1'b1;
                    next_state.rdata = link_host_control_pkg::ALL_ONES;
                end else begin
                    next_state.abort = 1'b1;
                    next_state.rdata = 32'h00000000;
                end
            end else begin
                next_state.ack   = 1'b1;
                next_state.rdata = 32'h00000000;
                if (!reg_write) begin
                    if (hit_set || hit_clr) begin
                        next_state.rdata = ctrl_view;
                    end else if (hit_sid) begin
                        next_state.rdata = {state.self_id_base, 11'h000};
                    end
                end else if (hit_set) begin
                    // Ones at the set address set the matching writable bits.
                    if (reg_wdata[link_host_control_pkg::ENHANCE_BIT]) begin
                        next_state.phy_enhancement_enable = 1'b1;
                    end
                    if (reg_wdata[link_host_control_pkg::POWER_BIT]) begin
                        next_state.link_power_status = 1'b1;
                    end
                    if (reg_wdata[link_host_control_pkg::POSTED_BIT]) begin
                        next_state.posted_write_allow = 1'b1;
                    end
                    if (reg_wdata[link_host_control_pkg::LINK_ACTIVE_BIT]) begin
                        next_state.link_active_switch = 1'b1;
                    end
                end else if (hit_clr) begin
                    // Ones at the clear address clear the matching writable bits.
                    if (reg_wdata[link_host_control_pkg::ENHANCE_BIT]) begin
                        next_state.phy_enhancement_enable = 1'b0;
                    end
                    if (reg_wdata[link_host_control_pkg::POWER_BIT]) begin
                        next_state.link_power_status = 1'b0;
                    end
                    if (reg_wdata[link_host_control_pkg::POSTED_BIT]) begin
                        next_state.posted_write_allow = 1'b0;
                    end
                    if (reg_wdata[link_host_control_pkg::LINK_ACTIVE_BIT]) begin
                        next_state.link_active_switch = 1'b0;
                    end
                end else if (hit_sid) begin
                    // Only the aligned upper bits are stored.
                    next_state.self_id_base = reg_wdata[31:link_host_control_pkg::SID_LSB];
                end
            end
        end
        // A software reset returns enhancement, posted write, link active and self-ID base to reset values; link power status is kept.
        if (reset_busy || reset_start) begin
            next_state.phy_enhancement_enable = link_host_control_pkg::CTRL_BIT_RESET;
            next_state.posted_write_allow     = link_host_control_pkg::CTRL_BIT_RESET;
            next_state.link_active_switch     = link_host_control_pkg::CTRL_BIT_RESET;
            next_state.self_id_base           = link_host_control_pkg::SID_RESET;
        end
        // Counts the cycles of a running software reset so its length can be checked.
        if (reset_busy) begin
            next_state.busy_len = state.busy_len + 1'b1;
        end else begin
            next_state.busy_len = '0;
        end
        // Traffic stops at once whenever the link is inactive or resetting.
        next_state.traffic = next_state.link_active_switch && !reset_busy &&
                             !reset_start;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------

    // Registers the state copy; hardware reset restores every default.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state                        <= '0;
            state.phy_config_permit      <= link_host_control_pkg::CFG_PERMIT_RESET;
            state.link_active_switch     <= link_host_control_pkg::CTRL_BIT_RESET;
            state.self_id_base           <= link_host_control_pkg::SID_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    // Every output is taken straight from a flip-flop.
    assign reg_rdata              = state.rdata;
    assign reg_ack                = state.ack;
    assign reg_abort              = state.abort;
    assign phy_comm_enable        = state.link_power_status;
    assign link_traffic_enable    = state.traffic;
    assign posted_write_allow_out = state.posted_write_allow;
    assign phy_enhancements_on    = state.phy_enhancement_enable;
    assign link_state_reset       = reset_busy;
    assign self_id_base_addr      = {state.self_id_base, 11'h000};

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    reserved_zero_a: assert property ((reg_req && !reg_write && (hit_set || hit_clr) && !phy_domain)
        |=> (reg_rdata[21:20] == 2'b00) && (reg_rdata[15:0] == 16'h0000))
        else $error("Reserved host control bits read nonzero.");

    power_gate_a: assert property ((reg_req && reg_write && hit_clr && reg_wdata[19])
        |=> !phy_comm_enable)
        else $error("PHY communication still enabled after power status clear.");

    stopped_abort_a: assert property ((reg_req && phy_domain && !phy_clock_running && !abort_suppress)
        |=> reg_abort && !reg_ack)
        else $error("Stopped PHY clock access did not abort.");

    suppress_ones_a: assert property ((reg_req && phy_domain && !phy_clock_running && abort_suppress)
        |=> reg_ack && !reg_abort && (reg_rdata == 32'hFFFFFFFF))
        else $error("Suppressed abort did not return all ones.");

    posted_set_a: assert property ((reg_req && reg_write && hit_set && reg_wdata[18] && !reg_wdata[16]
        && !reset_busy) |=> posted_write_allow_out)
        else $error("Posted write bit did not set.");

    soft_clear_a: assert property ($rose(reset_busy) |-> !link_traffic_enable && (state.link_active_switch == 1'b0))
        else $error("Link active not cleared by software reset.");

    traffic_stop_a: assert property (!state.link_active_switch |-> !link_traffic_enable)
        else $error("Traffic enabled while link inactive.");

    reset_length_a: assert property ($fell(reset_busy) |-> (state.busy_len == BW'(SOFT_RESET_LEN)))
        else $error("Software reset did not last its full length.");

    sid_align_a: assert property (self_id_base_addr[10:0] == 11'h000)
        else $error("Self-ID base low bits not zero.");

    permit_load_a: assert property ((eeprom_load && !reset) |=> state.phy_config_permit == $past(eeprom_phy_config_permit))
        else $error("Config permit not loaded.");

    answer_once_a: assert property (reg_req |=> (reg_ack != reg_abort))
        else $error("Access not answered by exactly one of ack and abort.");

    idle_quiet_a: assert property (!reg_req |=> !reg_ack && !reg_abort)
        else $error("Answer given without a request.");

    posted_clear_a: assert property ((reg_req && reg_write && hit_clr && reg_wdata[18])
        |=> !posted_write_allow_out)
        else $error("Posted write bit did not clear.");

    sid_store_a: assert property ((reg_req && reg_write && hit_sid && !reset_busy)
        |=> self_id_base_addr == ($past(reg_wdata) & 32'hFFFFF800))
        else $error("Self-ID base did not store the aligned bits.");

    permit_hold_a: assert property ((reg_req && reg_write && !eeprom_load)
        |=> $stable(state.phy_config_permit))
        else $error("Config permit changed by a register write.");

    soft_defaults_a: assert property (reset_start
        |=> (self_id_base_addr == 32'h00000000) && !phy_enhancements_on && !posted_write_allow_out)
        else $error("Software reset left link registers set.");

    sid_write_c: cover property (reg_req && reg_write && hit_sid ##1 reg_ack);
    abort_c:     cover property (reg_abort);
    reset_run_c: cover property ($fell(reset_busy));
    link_up_c:   cover property ($rose(link_traffic_enable));

endmodule

// file: tb/phy_clock_model.sv
`timescale 1ns/100ps

// ------------------------------------------------------------
// PHY clock source seen from the link
// ------------------------------------------------------------
// The PHY clock starts only after link power is granted and a settling time
// has passed, so accesses made too early still meet a stopped clock.
module phy_clock_model #(
    parameter int STABLE_CYCLES = 8
) (
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic phy_comm_enable,
    output logic      phy_clock_running
);
    int count = 0;

    initial phy_clock_running = 1'b0;

    // Counts settling cycles while link power is on and stops at once when it drops.
    always @(negedge ref_clk) begin
        if (reset || (phy_comm_enable !== 1'b1)) begin
            count             <= 0;
            phy_clock_running <= 1'b0;
        end else if (count < STABLE_CYCLES) begin
            count <= count + 1;
        end else begin
            phy_clock_running <= 1'b1;
        end
    end
endmodule

// file: tb/link_host_control_selfid_ptr_tb.sv
`timescale 1ns/100ps

// ------------------------------------------------------------
// Bench for the host control and self-ID base registers
// ------------------------------------------------------------
module link_host_control_selfid_ptr_tb;
    localparam int          SR_LEN = 4;
    localparam logic [11:0] SET    = link_host_control_pkg::HOST_CTRL_SET_OFS;
    localparam logic [11:0] CLR    = link_host_control_pkg::HOST_CTRL_CLR_OFS;
    localparam logic [11:0] SID    = link_host_control_pkg::SELF_ID_BASE_OFS;

    logic        ref_clk                  = 1'b0;
    logic        reset                    = 1'b1;
    logic        reg_req                  = 1'b0;
    logic        reg_write                = 1'b0;
    logic [11:0] reg_addr                 = 12'h000;
    logic [31:0] reg_wdata                = 32'h00000000;
    logic        abort_suppress           = 1'b0;
    logic        eeprom_load              = 1'b0;
    logic        eeprom_phy_config_permit = 1'b1;
    logic [31:0] reg_rdata;
    logic        reg_ack;
    logic        reg_abort;
    logic        phy_clock_running;
    logic        phy_comm_enable;
    logic        link_traffic_enable;
    logic        posted_write_allow_out;
    logic        phy_enhancements_on;
    logic        link_state_reset;
    logic [31:0] self_id_base_addr;
    int          err_total = 0;
    int          tests_run = 0;
    int          cycles    = 0;
    int          n;
    logic [11:0] phy_addrs [5] = '{12'h0DC, 12'h0E0, 12'h0F0, 12'h100, 12'h11C};

    // Free-running 100 MHz clock.
    always #5 ref_clk = ~ref_clk;

    link_host_control_selfid_ptr #(.SOFT_RESET_LEN(SR_LEN)) i_dut (
        .ref_clk                  (ref_clk),
        .reset                    (reset),
        .reg_req                  (reg_req),
        .reg_write                (reg_write),
        .reg_addr                 (reg_addr),
        .reg_wdata                (reg_wdata),
        .reg_rdata                (reg_rdata),
        .reg_ack                  (reg_ack),
        .reg_abort                (reg_abort),
        .phy_clock_running        (phy_clock_running),
        .abort_suppress           (abort_suppress),
        .eeprom_load              (eeprom_load),
        .eeprom_phy_config_permit (eeprom_phy_config_permit),
        .phy_comm_enable          (phy_comm_enable),
        .link_traffic_enable      (link_traffic_enable),
        .posted_write_allow_out   (posted_write_allow_out),
        .phy_enhancements_on      (phy_enhancements_on),
        .link_state_reset         (link_state_reset),
        .self_id_base_addr        (self_id_base_addr)
    );

    phy_clock_model #(.STABLE_CYCLES(8)) i_phy (
        .ref_clk           (ref_clk),
        .reset             (reset),
        .phy_comm_enable   (phy_comm_enable),
        .phy_clock_running (phy_clock_running)
    );

    // ------------------------------------------------------------
    // Comparison and access tasks
    // ------------------------------------------------------------
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    // One access: a single-cycle request; the answer is checked in the cycle after it is taken, while it stands.
    task automatic xfer(input logic is_wr, input logic [11:0] a, input logic [31:0] d,
                        input logic [31:0] exp, input logic exp_ab);
        @(negedge ref_clk);
        reg_req   = 1'b1;
        reg_write = is_wr;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge ref_clk);
        reg_req = 1'b0;
        check_bit(reg_ack, ~exp_ab, "ack");
        check_bit(reg_abort, exp_ab, "abort");
        if (!exp_ab) check_word(reg_rdata, exp, "rdata");
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 32'h00000000, 1'b0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h00000000, exp, 1'b0);
    endtask

    task automatic complete_run();
        if (err_total == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Cuts a hang short well beyond the length of the sequence below.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            complete_run();
        end
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(negedge ref_clk);
        reset = 1'b0;
        rd(SET, 32'h00800000);
        rd(CLR, 32'h00800000);
        rd(SID, 32'h00000000);
        check_bit(phy_comm_enable, 1'b0, "power");
        check_bit(link_traffic_enable, 1'b0, "traffic");
        foreach (phy_addrs[i]) xfer(1'b0, phy_addrs[i], 32'h0, 32'h0, 1'b1);
        xfer(1'b1, 12'h0E0, 32'hFFFFFFFF, 32'h0, 1'b1);
        rd(12'h0D8, 32'h00000000);
        rd(12'h0F4, 32'h00000000);
        rd(12'h120, 32'h00000000);
        @(negedge ref_clk);
        abort_suppress = 1'b1;
        rd(12'h0E0, 32'hFFFFFFFF);
        rd(12'h11C, 32'hFFFFFFFF);
        @(negedge ref_clk);
        abort_suppress = 1'b0;
        wr(SET, 32'h00080000);
        check_bit(phy_comm_enable, 1'b1, "power");
        n = 0;
        while (phy_clock_running !== 1'b1 && n < 40) begin
            @(posedge ref_clk);
            n++;
        end
        rd(12'h0E0, 32'h00000000);
        wr(SET, 32'h0004FFFF);
        check_bit(posted_write_allow_out, 1'b1, "posted");
        wr(SET, 32'h00320000);
        check_bit(link_traffic_enable, 1'b1, "traffic");
        wr(SET, 32'hFF400000);
        check_bit(phy_enhancements_on, 1'b1, "enhance");
        rd(CLR, 32'h00CE0000);
        wr(CLR, 32'h00800000);
        rd(SET, 32'h00CE0000);
        wr(CLR, 32'h00420000);
        check_bit(link_traffic_enable, 1'b0, "traffic");
        check_bit(phy_enhancements_on, 1'b0, "enhance");
        rd(SET, 32'h008C0000);
        wr(SID, 32'hFFFFFFFF);
        rd(SID, 32'hFFFFF800);
        check_word(self_id_base_addr, 32'hFFFFF800, "base out");
        wr(SID, 32'h12345A5A);
        rd(SID, 32'h12345800);
        wr(SET, 32'h00020000);
        wr(SET, 32'h00410000);
        check_bit(link_state_reset, 1'b1, "busy");
        check_bit(link_traffic_enable, 1'b0, "traffic");
        rd(SET, 32'h00890000);
        rd(SID, 32'h00000000);
        n = 0;
        while (link_state_reset === 1'b1 && n < SR_LEN + 4) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check_bit(link_state_reset, 1'b0, "busy");
        rd(SET, 32'h00880000);
        check_bit(posted_write_allow_out, 1'b0, "posted");
        @(negedge ref_clk);
        eeprom_phy_config_permit = 1'b0;
        eeprom_load              = 1'b1;
        @(negedge ref_clk);
        eeprom_load = 1'b0;
        rd(SET, 32'h00080000);
        wr(SET, 32'h00800000);
        rd(SET, 32'h00080000);
        @(negedge ref_clk);
        eeprom_phy_config_permit = 1'b1;
        eeprom_load              = 1'b1;
        @(negedge ref_clk);
        eeprom_load = 1'b0;
        wr(SET, 32'h00020000);
        @(negedge ref_clk);
        reset = 1'b1;
        repeat (2) @(negedge ref_clk);
        reset = 1'b0;
        rd(SET, 32'h00800000);
        check_bit(link_traffic_enable, 1'b0, "traffic");
        complete_run();
    end
endmodule
